// ===== core/tmrp_top.sv
// two pairs of cascadable 8-bit interval timers with output flip-flops and apb registers
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module tmrp_top
  import tmrp_pkg::*;
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // external count clock of timer 0
  input  wire logic        TIMER0_EXT_CLK,
  // timer outputs
  output logic             PAIR_A_OUTPUT_PIN,
  output logic             PAIR_B_OUTPUT_PIN,
  // interrupt pulses
  output logic             TIMER0_INTERRUPT,
  output logic             TIMER1_INTERRUPT,
  output logic             TIMER2_INTERRUPT,
  output logic             TIMER3_INTERRUPT
);

  logic [7:0]            run_control_register;
  tmrp_mode_t            mode_q [2];
  tmrp_ffctl_t           ffctl_q [2];
  logic [1:0]            double_buffer_control;
  logic [TMRP_PRE_W-1:0] pre_cnt;
  logic                  tick_t1;
  logic                  tick_t4;
  logic                  tick_t16;
  logic                  tick_t256;
  logic                  ext_s1;
  logic                  ext_s2;
  logic                  ext_s3;
  logic                  ext_tick;
  tmrp_wreq_t            wreq;
  logic                  idx_ok;
  logic                  mapped;
  logic [31:0]           next_prdata;
  logic [1:0]            out_ff;
  logic [3:0]            irq_q;

  // zero wait states: every access completes in its first access cycle
  assign PREADY = 1'b1;

  // writes take effect only in the access phase; low byte lane carries the data
  always_comb begin
    wreq.wr   = PSEL & PENABLE & PWRITE & PSTRB[0] & idx_ok;
    wreq.idx  = PADDR[11:2];
    wreq.data = PWDATA[7:0];
  end

  // address decode, misaligned addresses count as unmapped
  always_comb begin
    unique case (PADDR[11:2])
      TMRP_RUN_IDX, TMRP_T0_CMP_IDX, TMRP_T1_CMP_IDX, TMRP_MODE_A_IDX,
      TMRP_MODE_B_IDX, TMRP_T2_CMP_IDX, TMRP_T3_CMP_IDX, TMRP_FFCTL_IDX,
      TMRP_DBUF_IDX: mapped = 1'b1;
      default:       mapped = 1'b0;
    endcase
    idx_ok = mapped & (PADDR[1:0] == 2'h0);
  end

  // read mux; flip-flop state and compare values are deliberately absent
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (PADDR[11:2])
      TMRP_RUN_IDX:    next_prdata = {24'h00_0000, run_control_register};
      TMRP_MODE_A_IDX: next_prdata = {24'h00_0000, mode_q[0]};
      TMRP_MODE_B_IDX: next_prdata = {24'h00_0000, mode_q[1]};
      TMRP_FFCTL_IDX:  next_prdata = {24'h00_0000, ffctl_q[1].inv_sel, ffctl_q[1].inv_en,
                                      TMRP_FF_KEEP, ffctl_q[0].inv_sel, ffctl_q[0].inv_en,
                                      TMRP_FF_KEEP};
      TMRP_DBUF_IDX:   next_prdata = {30'h0000_0000, double_buffer_control};
      default:         next_prdata = 32'h0000_0000;
    endcase
  end

  // read data and error are captured in the setup phase so they come from flip-flops
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : next_prdata;
      PSLVERR <= ~idx_ok;
    end
  end

  // run control register
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      run_control_register <= TMRP_RUN_RST;
    end else if (wreq.wr && wreq.idx == TMRP_RUN_IDX) begin
      run_control_register <= wreq.data;
    end
  end

  // mode registers
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q[0] <= TMRP_MODE_RST;
      mode_q[1] <= TMRP_MODE_RST;
    end else if (wreq.wr) begin
      if (wreq.idx == TMRP_MODE_A_IDX) begin
        mode_q[0] <= wreq.data;
      end
      if (wreq.idx == TMRP_MODE_B_IDX) begin
        mode_q[1] <= wreq.data;
      end
    end
  end

  // flip-flop control: inversion enable and select are stored, commands act once
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ffctl_q[0] <= TMRP_FFCTL_RST;
      ffctl_q[1] <= TMRP_FFCTL_RST;
    end else if (wreq.wr && wreq.idx == TMRP_FFCTL_IDX) begin
      ffctl_q[0] <= {wreq.data[3:2], TMRP_FF_KEEP};
      ffctl_q[1] <= {wreq.data[7:6], TMRP_FF_KEEP};
    end
  end

  // double buffer enables, off after reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      double_buffer_control <= TMRP_DBUF_RST;
    end else if (wreq.wr && wreq.idx == TMRP_DBUF_IDX) begin
      double_buffer_control <= wreq.data[1:0];
    end
  end

  // prescaler held at zero while stopped, so a start always counts from zero
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pre_cnt <= TMRP_PRE_RST;
    end else if (!run_control_register[TMRP_RUN_PRE_BIT]) begin
      pre_cnt <= TMRP_PRE_RST;
    end else begin
      pre_cnt <= pre_cnt + 11'h001;
    end
  end

  // prescaler taps: one-cycle enables at fc/8, fc/32, fc/128 and fc/2048
  always_comb begin
    tick_t1   = run_control_register[TMRP_RUN_PRE_BIT] &
                ((pre_cnt & TMRP_T1_MASK) == TMRP_T1_MASK);
    tick_t4   = run_control_register[TMRP_RUN_PRE_BIT] &
                ((pre_cnt & TMRP_T4_MASK) == TMRP_T4_MASK);
    tick_t16  = run_control_register[TMRP_RUN_PRE_BIT] &
                ((pre_cnt & TMRP_T16_MASK) == TMRP_T16_MASK);
    tick_t256 = run_control_register[TMRP_RUN_PRE_BIT] &
                ((pre_cnt & TMRP_T256_MASK) == TMRP_T256_MASK);
  end

  // external clock pin: two-stage synchroniser, edge found from the second stage on
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= TIMER0_EXT_CLK;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  assign ext_tick = ext_s2 & ~ext_s3;

  // one pair of timers per iteration
  for (genvar p = 0; p < 2; p++) begin : g_pair
    localparam logic [9:0] LO_IDX = (p == 0) ? TMRP_T0_CMP_IDX : TMRP_T2_CMP_IDX;
    localparam logic [9:0] HI_IDX = (p == 0) ? TMRP_T1_CMP_IDX : TMRP_T3_CMP_IDX;

    tmrp_mode_t  md;
    tmrp_ffctl_t fc;
    logic        lo_run;
    logic        hi_run;
    logic        dbuf_en;
    logic [7:0]  lo_cnt;
    logic [7:0]  hi_cnt;
    logic [7:0]  lo_cmp;
    logic [7:0]  hi_cmp;
    logic [7:0]  lo_shadow;
    logic        hold;
    logic        lo_tick;
    logic        hi_tick;
    logic [7:0]  lo_next;
    logic [7:0]  hi_next;
    logic        lo_ovf;
    logic        lo_hit;
    logic        hi_hit;
    logic [15:0] wide_next;
    logic        match16;
    logic        ppg_end;
    logic        ppg_duty;
    logic [7:0]  pwm_top;
    logic        pwm_end;
    logic        pwm_duty;
    logic        lo_clear;
    logic        hi_clear;
    logic        irq_lo;
    logic        irq_hi;
    logic        hw_toggle;
    logic        load_shadow;
    logic        wr_lo;
    logic        wr_hi;
    logic        ff_cmd_wr;
    logic [1:0]  ff_cmd;

    assign md      = mode_q[p];
    assign fc      = ffctl_q[p];
    assign lo_run  = run_control_register[2*p];
    assign hi_run  = run_control_register[2*p+1];
    assign dbuf_en = double_buffer_control[p];
    assign wr_lo   = wreq.wr && wreq.idx == LO_IDX;
    assign wr_hi   = wreq.wr && wreq.idx == HI_IDX;

    // lower count clock; the second pair has no external pin and stays still on it
    always_comb begin
      unique case (md.lo_clk)
        TMRP_LCLK_EXT: lo_tick = lo_run & ((p == 0) ? ext_tick : 1'b0);
        TMRP_LCLK_T1:  lo_tick = lo_run & tick_t1;
        TMRP_LCLK_T4:  lo_tick = lo_run & tick_t4;
        TMRP_LCLK_T16: lo_tick = lo_run & tick_t16;
      endcase
    end

    // lower comparator; a zero value means the full 256 count
    always_comb begin
      lo_next = lo_cnt + 8'h01;
      lo_ovf  = lo_tick & (lo_cnt == 8'hff);
      lo_hit  = lo_tick & ((lo_cmp == 8'h00) ? (lo_cnt == 8'hff)
                                             : (lo_next == lo_cmp));
    end

    // upper count clock: cascade forces the lower overflow
    always_comb begin
      if (md.mode == TMRP_M_16BIT) begin
        hi_tick = hi_run & lo_ovf;
      end else begin
        unique case (md.hi_clk)
          TMRP_HCLK_MATCH: hi_tick = hi_run & lo_hit;
          TMRP_HCLK_T1:    hi_tick = hi_run & tick_t1;
          TMRP_HCLK_T16:   hi_tick = hi_run & tick_t16;
          TMRP_HCLK_T256:  hi_tick = hi_run & tick_t256;
        endcase
      end
    end

    // upper comparator
    always_comb begin
      hi_next = hi_cnt + 8'h01;
      hi_hit  = hi_tick & ((hi_cmp == 8'h00) ? (hi_cnt == 8'hff)
                                             : (hi_next == hi_cmp));
    end

    // cascade: both halves must agree at once, and never while suspended
    always_comb begin
      wide_next = {hi_cnt, lo_cnt} + 16'h0001;
      match16   = lo_tick & ~hold &
                  (({hi_cmp, lo_cmp} == 16'h0000) ? ({hi_cnt, lo_cnt} == 16'hffff)
                                                  : (wide_next == {hi_cmp, lo_cmp}));
    end

    // pulse mode: lower compare sets duty, upper compare sets the cycle
    always_comb begin
      ppg_duty = lo_tick & (lo_next == lo_cmp);
      ppg_end  = lo_tick & ((hi_cmp == 8'h00) ? (lo_cnt == 8'hff)
                                              : (lo_next == hi_cmp));
    end

    // pwm on the lower timer: cycle ends at 2^n-1
    always_comb begin
      unique case (md.pwm_len)
        2'h1:    pwm_top = TMRP_PWM6_END;
        2'h2:    pwm_top = TMRP_PWM7_END;
        default: pwm_top = TMRP_PWM8_END;
      endcase
      pwm_end  = lo_tick & (lo_next == pwm_top);
      pwm_duty = lo_tick & (lo_next == lo_cmp);
    end

    // per-mode clear, interrupt and inversion sources
    always_comb begin
      lo_clear  = 1'b0;
      hi_clear  = 1'b0;
      irq_lo    = 1'b0;
      irq_hi    = 1'b0;
      hw_toggle = 1'b0;
      unique case (md.mode)
        TMRP_M_8BIT: begin
          lo_clear  = lo_hit;
          hi_clear  = hi_hit;
          irq_lo    = lo_hit;
          irq_hi    = hi_hit;
          hw_toggle = fc.inv_en & (fc.inv_sel ? hi_hit : lo_hit);
        end
        TMRP_M_16BIT: begin
          lo_clear  = match16;
          hi_clear  = match16;
          irq_hi    = match16;
          hw_toggle = fc.inv_en & match16;
        end
        TMRP_M_PPG: begin
          lo_clear  = ppg_end;
          irq_lo    = ppg_end;
          hw_toggle = fc.inv_en & (ppg_end | ppg_duty);
        end
        TMRP_M_PWM: begin
          lo_clear  = pwm_end;
          hi_clear  = hi_hit;
          irq_lo    = pwm_end;
          irq_hi    = hi_hit;
          hw_toggle = fc.inv_en & (pwm_end | pwm_duty);
        end
      endcase
      load_shadow = dbuf_en & (((md.mode == TMRP_M_PPG) & ppg_end) |
                               ((md.mode == TMRP_M_PWM) & pwm_end));
    end

    // lower up-counter; a cleared run bit holds it at zero
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        lo_cnt <= TMRP_CNT_RST;
      end else if (!lo_run || lo_clear) begin
        lo_cnt <= TMRP_CNT_RST;
      end else if (lo_tick) begin
        lo_cnt <= lo_next;
      end
    end

    // upper up-counter; unused in pulse mode
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        hi_cnt <= TMRP_CNT_RST;
      end else if (!hi_run || hi_clear || md.mode == TMRP_M_PPG) begin
        hi_cnt <= TMRP_CNT_RST;
      end else if (hi_tick) begin
        hi_cnt <= hi_next;
      end
    end

    // shadow buffer and lower compare share one address
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        lo_shadow <= TMRP_CMP_RST;
        lo_cmp    <= TMRP_CMP_RST;
      end else begin
        if (wr_lo) begin
          lo_shadow <= wreq.data;
        end
        // with buffering on a write reaches only the shadow; a same-cycle load takes the old shadow value
        if (wr_lo && !dbuf_en) begin
          lo_cmp <= wreq.data;
        end else if (load_shadow) begin
          lo_cmp <= lo_shadow;
        end
      end
    end

    // upper compare register, unbuffered
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        hi_cmp <= TMRP_CMP_RST;
      end else if (wr_hi) begin
        hi_cmp <= wreq.data;
      end
    end

    // cascade suspend: stops half-written 16-bit values from matching early
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        hold <= 1'b0;
      end else if (wr_hi) begin
        hold <= 1'b0;
      end else if (wr_lo && md.mode == TMRP_M_16BIT) begin
        hold <= 1'b1;
      end
    end

    // software command for this pair's flip-flop
    assign ff_cmd_wr = wreq.wr && wreq.idx == TMRP_FFCTL_IDX;
    assign ff_cmd    = wreq.data[TMRP_FFCTL_PAIR_W*p +: 2];

    // output flip-flop; a software command overrides a same-cycle hardware toggle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        out_ff[p] <= 1'b0;
      end else if (ff_cmd_wr && ff_cmd != TMRP_FF_KEEP) begin
        unique case (ff_cmd)
          TMRP_FF_INV: out_ff[p] <= ~out_ff[p];
          TMRP_FF_SET: out_ff[p] <= 1'b1;
          TMRP_FF_CLR: out_ff[p] <= 1'b0;
          default:     out_ff[p] <= out_ff[p];
        endcase
      end else if (hw_toggle) begin
        out_ff[p] <= ~out_ff[p];
      end
    end

    // interrupt pulses registered for clean outputs
    always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
        irq_q[2*p]   <= 1'b0;
        irq_q[2*p+1] <= 1'b0;
      end else begin
        irq_q[2*p]   <= irq_lo;
        irq_q[2*p+1] <= irq_hi;
      end
    end
  end

  // one flip-flop per pair drives its own pin
  assign PAIR_A_OUTPUT_PIN = out_ff[0];
  assign PAIR_B_OUTPUT_PIN = out_ff[1];
  assign TIMER0_INTERRUPT  = irq_q[0];
  assign TIMER1_INTERRUPT  = irq_q[1];
  assign TIMER2_INTERRUPT  = irq_q[2];
  assign TIMER3_INTERRUPT  = irq_q[3];

endmodule // tmrp_top

`default_nettype wire

// ===== core/tmrp_pkg.sv
// constants, field layouts and carrier types of the interval timer pair block
package tmrp_pkg;

  // register indices: byte address is four times the index
  localparam logic [9:0] TMRP_RUN_IDX    = 10'h020;
  localparam logic [9:0] TMRP_T0_CMP_IDX = 10'h022;
  localparam logic [9:0] TMRP_T1_CMP_IDX = 10'h023;
  localparam logic [9:0] TMRP_MODE_A_IDX = 10'h024;
  localparam logic [9:0] TMRP_MODE_B_IDX = 10'h025;
  localparam logic [9:0] TMRP_T2_CMP_IDX = 10'h026;
  localparam logic [9:0] TMRP_T3_CMP_IDX = 10'h027;
  localparam logic [9:0] TMRP_FFCTL_IDX  = 10'h028;
  localparam logic [9:0] TMRP_DBUF_IDX   = 10'h029;

  // values after reset
  localparam logic [7:0] TMRP_RUN_RST   = 8'h00;
  localparam logic [7:0] TMRP_MODE_RST  = 8'h00;
  localparam logic [3:0] TMRP_FFCTL_RST = 4'h0;
  localparam logic [1:0] TMRP_DBUF_RST  = 2'h0;
  localparam logic [7:0] TMRP_CMP_RST   = 8'h00;
  localparam logic [7:0] TMRP_CNT_RST   = 8'h00;

  // run register field positions
  localparam int TMRP_RUN_PRE_BIT = 7;

  // prescaler: 11-bit counter running at fc, with the taps used by the timers
  localparam int          TMRP_PRE_W     = 11;
  localparam logic [10:0] TMRP_PRE_RST   = 11'h000;
  localparam logic [10:0] TMRP_T1_MASK   = 11'h007;
  localparam logic [10:0] TMRP_T4_MASK   = 11'h01f;
  localparam logic [10:0] TMRP_T16_MASK  = 11'h07f;
  localparam logic [10:0] TMRP_T256_MASK = 11'h7ff;

  // operating modes of a pair
  localparam logic [1:0] TMRP_M_8BIT  = 2'h0;
  localparam logic [1:0] TMRP_M_16BIT = 2'h1;
  localparam logic [1:0] TMRP_M_PPG   = 2'h2;
  localparam logic [1:0] TMRP_M_PWM   = 2'h3;

  // lower timer clock selects
  localparam logic [1:0] TMRP_LCLK_EXT = 2'h0;
  localparam logic [1:0] TMRP_LCLK_T1  = 2'h1;
  localparam logic [1:0] TMRP_LCLK_T4  = 2'h2;
  localparam logic [1:0] TMRP_LCLK_T16 = 2'h3;

  // upper timer clock selects
  localparam logic [1:0] TMRP_HCLK_MATCH = 2'h0;
  localparam logic [1:0] TMRP_HCLK_T1    = 2'h1;
  localparam logic [1:0] TMRP_HCLK_T16   = 2'h2;
  localparam logic [1:0] TMRP_HCLK_T256  = 2'h3;

  // pwm cycle length codes and their 2^n-1 end values
  localparam logic [7:0] TMRP_PWM6_END = 8'h3f;
  localparam logic [7:0] TMRP_PWM7_END = 8'h7f;
  localparam logic [7:0] TMRP_PWM8_END = 8'hff;

  // output flip-flop commands
  localparam logic [1:0] TMRP_FF_INV  = 2'h0;
  localparam logic [1:0] TMRP_FF_SET  = 2'h1;
  localparam logic [1:0] TMRP_FF_CLR  = 2'h2;
  localparam logic [1:0] TMRP_FF_KEEP = 2'h3;

  // field positions of the flip-flop control register, per pair
  localparam int TMRP_FFCTL_PAIR_W = 4;

  // mode register of one pair
  typedef struct packed {
    logic [1:0] pwm_len;
    logic [1:0] mode;
    logic [1:0] hi_clk;
    logic [1:0] lo_clk;
  } tmrp_mode_t;

  // flip-flop control of one pair
  typedef struct packed {
    logic       inv_sel;
    logic       inv_en;
    logic [1:0] cmd;
  } tmrp_ffctl_t;

  // decoded bus request
  typedef struct packed {
    logic       wr;
    logic [9:0] idx;
    logic [7:0] data;
  } tmrp_wreq_t;

endpackage : tmrp_pkg

// ===== testbench/tmrp_assertions.sv
// assertion checker for the interval timer pair block
`timescale 1ns/1ps
`default_nettype none

module tmrp_checker
  import tmrp_pkg::*;
(
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        RESETN,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  // timer side
  input wire logic        PAIR_A_OUTPUT_PIN,
  input wire logic        PAIR_B_OUTPUT_PIN,
  input wire logic        TIMER1_INTERRUPT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  // access-cycle reads; judged there because read data stands from setup on
  wire logic rd_acc = PSEL && PENABLE && !PWRITE;
  wire logic cmp_rd = rd_acc && PADDR[11:2] inside {TMRP_T0_CMP_IDX, TMRP_T1_CMP_IDX,
                                                   TMRP_T2_CMP_IDX, TMRP_T3_CMP_IDX};
  wire logic ff_rd  = rd_acc && PADDR == {TMRP_FFCTL_IDX, 2'h0};

  // a flip-flop control write that the block accepts
  sequence ff_wr;
    PSEL && PENABLE && PWRITE && PSTRB[0] && PADDR == {TMRP_FFCTL_IDX, 2'h0};
  endsequence

  cmp_unread_a: assert property (cmp_rd |-> PRDATA == 32'h0)
    else $error("compare value readable");
  ff_hidden_a: assert property (ff_rd |-> {PRDATA[5:4], PRDATA[1:0]} == 4'hf)
    else $error("flip-flop state readable");
  a_invert_a: assert property (ff_wr ##0 PWDATA[1:0] == 2'h0 |=> $changed(PAIR_A_OUTPUT_PIN))
    else $error("pin a not inverted");
  a_set_a: assert property (ff_wr ##0 PWDATA[1:0] == 2'h1 |=> PAIR_A_OUTPUT_PIN)
    else $error("pin a not set");
  a_clear_a: assert property (ff_wr ##0 PWDATA[1:0] == 2'h2 |=> !PAIR_A_OUTPUT_PIN)
    else $error("pin a not cleared");
  b_set_a: assert property (ff_wr ##0 PWDATA[5:4] == 2'h1 |=> PAIR_B_OUTPUT_PIN)
    else $error("pin b not set");
  b_invert_a: assert property (ff_wr ##0 PWDATA[5:4] == 2'h0 |=> $changed(PAIR_B_OUTPUT_PIN))
    else $error("pin b not inverted");
  irq_pulse_a: assert property (TIMER1_INTERRUPT |=> !TIMER1_INTERRUPT [*7])
    else $error("timer1 interrupt too long or too dense");
endmodule // tmrp_checker

bind tmrp_top tmrp_checker chk_u (.REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
  .PRDATA(PRDATA), .PAIR_A_OUTPUT_PIN(PAIR_A_OUTPUT_PIN),
  .PAIR_B_OUTPUT_PIN(PAIR_B_OUTPUT_PIN), .TIMER1_INTERRUPT(TIMER1_INTERRUPT));
`default_nettype wire

// ===== testbench/tmrp_top_tb.sv
// self-checking testbench for the interval timer pair block
`timescale 1ns/1ps
`default_nettype none

module tmrp_top_tb
  import tmrp_pkg::*;
();
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_a;
  logic        pin_b;
  logic [3:0]  irq;
  logic [31:0] rdat;
  logic        err;
  logic        p1;
  logic [7:0]  cmds [5] = '{8'h31, 8'h30, 8'h32, 8'h30, 8'h13};
  logic [4:0]  expa = 5'h19;
  logic [4:0]  expb = 5'h10;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          t0_seen = 0;
  int          n;
  int          k;

  // external clock pin tied low: timer 0 runs from the prescaler only
  tmrp_top dut_u (
    .REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMER0_EXT_CLK(1'b0),
    .PAIR_A_OUTPUT_PIN(pin_a), .PAIR_B_OUTPUT_PIN(pin_b), .TIMER0_INTERRUPT(irq[0]),
    .TIMER1_INTERRUPT(irq[1]), .TIMER2_INTERRUPT(irq[2]), .TIMER3_INTERRUPT(irq[3]));

  // 40 mhz clock
  always #12.5 ref_clk = ~ref_clk;

  // timer 0 pulses counted on the falling edge, clear of the update edge
  always @(negedge ref_clk) if (irq[0] === 1'b1) t0_seen++;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i >= 50) begin
      bad_count++;
      end_of_test();
    end
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check($sformatf("reg %h", idx), rdat, exp);
  endtask

  // cycles between two pulses of one interrupt, bounded
  task automatic period(input int x, output int c);
    int i;
    for (i = 0; i < 9000 && irq[x] !== 1'b1; i++) @(negedge ref_clk);
    // a pulse that never comes is a mismatch, not a silent pass
    if (i >= 9000) begin
      bad_count++;
      end_of_test();
    end
    @(negedge ref_clk);
    for (c = 1; c < 9000 && irq[x] !== 1'b1; c++) @(negedge ref_clk);
    if (c >= 9000) begin
      bad_count++;
      end_of_test();
    end
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(TMRP_RUN_IDX, 32'h0);
    rd(TMRP_DBUF_IDX, 32'h0);
    apb(1'b1, TMRP_T0_CMP_IDX, 8'h5a);
    rd(TMRP_T0_CMP_IDX, 32'h0);
    apb(1'b0, 10'h3ff, 8'h00);
    check("unmapped error", err, 1'b1);
    // software commands: set, invert, clear, invert on pair a, then set on pair b
    for (k = 0; k < 5; k++) begin
      apb(1'b1, TMRP_FFCTL_IDX, cmds[k]);
      @(negedge ref_clk);
      check("pin a", pin_a, expa[k]);
      check("pin b", pin_b, expb[k]);
    end
    rd(TMRP_FFCTL_IDX, 32'h33);
    // timer 1 interval of 3 ticks at fc/8, toggling pin a
    apb(1'b1, TMRP_FFCTL_IDX, 8'h3f);
    apb(1'b1, TMRP_T1_CMP_IDX, 8'h03);
    apb(1'b1, TMRP_MODE_A_IDX, 8'h04);
    apb(1'b1, TMRP_RUN_IDX, 8'h82);
    period(1, n);
    p1 = pin_a;
    period(1, n);
    check("timer1 period", n, 24);
    check("pin a toggle", pin_a, !p1);
    // cascade 0x0102 with a slow upper select that must be ignored
    apb(1'b1, TMRP_RUN_IDX, 8'h00);
    apb(1'b1, TMRP_MODE_A_IDX, 8'h1d);
    apb(1'b1, TMRP_T0_CMP_IDX, 8'h02);
    apb(1'b1, TMRP_T1_CMP_IDX, 8'h01);
    apb(1'b1, TMRP_RUN_IDX, 8'h83);
    period(1, n);
    p1 = pin_a;
    period(1, n);
    check("cascade period", n, 2064);
    check("cascade toggle", pin_a, !p1);
    check("timer0 quiet", t0_seen, 0);
    // buffered write must not reach timer 0; timer 3 compare zero waits 256 ticks
    apb(1'b1, TMRP_RUN_IDX, 8'h00);
    apb(1'b1, TMRP_MODE_A_IDX, 8'h01);
    apb(1'b1, TMRP_MODE_B_IDX, 8'h04);
    apb(1'b1, TMRP_T0_CMP_IDX, 8'h02);
    apb(1'b1, TMRP_T3_CMP_IDX, 8'h00);
    apb(1'b1, TMRP_DBUF_IDX, 8'h01);
    rd(TMRP_DBUF_IDX, 32'h1);
    apb(1'b1, TMRP_T0_CMP_IDX, 8'h05);
    apb(1'b1, TMRP_RUN_IDX, 8'h89);
    period(0, n);
    period(0, n);
    check("timer0 period", n, 16);
    period(3, n);
    period(3, n);
    check("timer3 period", n, 2048);
    // pulse mode on pair b: duty 1 tick, cycle 4 ticks at fc/8, inversion on
    apb(1'b1, TMRP_RUN_IDX, 8'h00);
    apb(1'b1, TMRP_FFCTL_IDX, 8'h73);
    apb(1'b1, TMRP_MODE_B_IDX, 8'h21);
    apb(1'b1, TMRP_T2_CMP_IDX, 8'h01);
    apb(1'b1, TMRP_T3_CMP_IDX, 8'h04);
    apb(1'b1, TMRP_RUN_IDX, 8'h84);
    period(2, n);
    period(2, n);
    check("ppg period", n, 32);
    p1 = pin_b;
    // mid-cycle the duty edge has flipped the pin, the cycle end has not yet
    repeat (16) @(negedge ref_clk);
    check("ppg duty", pin_b, !p1);
    end_of_test();
  end
endmodule // tmrp_top_tb
`default_nettype wire
